// File: rtl/lpi_mem.sv
// lpi_mem: one byte lane of array storage, all banks in one flat space.
// assumes one write and one read port; read data come out of a register.
`timescale 1ns/100ps
`include "lpi_regs.svh"
module lpi_mem
   import lpi_pkg::*;
(
   input  logic                   i_clock,
   input  logic                   i_rst,
   input  logic                   i_we,
   input  logic [`LPI_ADDR_W-1:0] i_waddr,
   input  logic [`LPI_BYTE_W-1:0] i_wdata,
   input  logic [`LPI_ADDR_W-1:0] i_raddr,
   output logic [`LPI_BYTE_W-1:0] o_rdata
);
   logic [`LPI_BYTE_W-1:0] mem_ff [0:`LPI_DEPTH-1];
   logic [`LPI_BYTE_W-1:0] rdata_ff;
   // array left without reset so it maps onto plain storage
   always_ff @(posedge i_clock) begin
      if (i_we) begin
         mem_ff[i_waddr] <= i_wdata;
      end
   end
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= mem_ff[i_raddr];
      end
   end

   assign o_rdata = rdata_ff;
endmodule : lpi_mem

// File: rtl/lpi_pkg.sv
// lpi_pkg: types shared by the lpi pin interface.
// assumes lpi_regs.svh is on the include path.
`include "lpi_regs.svh"
package lpi_pkg;
   typedef enum logic [2:0] {
      LPI_CMD_NOP   = 3'h0,
      LPI_CMD_ACT   = 3'h1,
      LPI_CMD_WR    = 3'h2,
      LPI_CMD_RD    = 3'h3,
      LPI_CMD_OTHER = 3'h4
   } lpi_cmd_t;
   typedef enum logic [0:0] {
      LPI_ST_IDLE = 1'h0,
      LPI_ST_READ = 1'h1
   } lpi_rd_st_t;
endpackage : lpi_pkg

// File: rtl/lpi_regs.svh
// lpi_regs.svh: widths, field positions, reset values and counts of the pin interface.
// assumes inclusion by bare name from every file of the lpi block except the synchroniser, which includes nothing.
`ifndef LPI_REGS_SVH
`define LPI_REGS_SVH
// Functional notes
// - command/address bus is captured on both clock edges, two words per cycle.
// - chip select and clock enable are captured on the positive clock edge only.
// - positive edge is rising true/falling complement crossing; negative is the reverse.
// - clock enable high runs internal clocks, receivers and drivers; low stops them.
// - power saving is entered and left only by clock enable transitions.
// - commands decode from clock enable, chip select and both address words; this block decodes the command from the rising word only.
// - device drives the strobe with read data; controller drives it with write data.
// - read strobe edges align with data; write strobe edges sit mid data eye.
// - in 32-bit mode strobe n qualifies data byte lane n, lanes 0 to 3.
// - in 16-bit mode only strobes 0 and 1 are used, lanes 0 and 1.
// - a write beat whose mask samples high with it is not stored.
// - masks are sampled on both strobe edges, one bit per byte per beat.
// - mask n governs data byte lane n; masks 2 and 3 only in 32-bit mode.
// - termination follows the termination enable pin, with mode-selected values.
// - each command takes one clock cycle, a word on each edge.
// - storage is eight banks, bank chosen by bits of the address bus.

// -------------------------------------------------------------------------
// widths
// -------------------------------------------------------------------------
`define LPI_CA_W      10
`define LPI_DQ_W      32
`define LPI_LANES     4
`define LPI_LANES_X16 2
`define LPI_BYTE_W    8
`define LPI_TERM_W    2
// -------------------------------------------------------------------------
// command field positions
// -------------------------------------------------------------------------
`define LPI_OP_LSB    0
`define LPI_OP_MSB    2
`define LPI_BANK_LSB  7
`define LPI_BANK_MSB  9
`define LPI_COL_LSB   0
`define LPI_COL_MSB   4
// -------------------------------------------------------------------------
// storage and burst
// -------------------------------------------------------------------------
`define LPI_BANK_W    3
`define LPI_COL_W     5
`define LPI_ADDR_W    8
`define LPI_DEPTH     256
`define LPI_BEAT_W    3
`define LPI_LAST_BEAT 3'h7
// -------------------------------------------------------------------------
// reset values
// -------------------------------------------------------------------------
`define LPI_RST_CKE   1'b0
`define LPI_RST_CS_N  1'b1
`endif

// File: rtl/lpi_sync.sv
// lpi_sync: two flip-flop synchroniser for a group of pin levels.
// assumes each bit is a level; bits of a word may settle one cycle apart.
`timescale 1ns/100ps
module lpi_sync
   import lpi_pkg::*;
#(
   parameter int W = 1
)
(
   input  logic         i_clock,
   input  logic         i_rst,
   input  logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= i_d;
         sync_ff <= meta_ff;
      end
   end

   assign o_q = sync_ff;
endmodule : lpi_sync

// File: rtl/lpi_top.sv
// lpi_top: pin interface of a low-power DDR memory die, oversampled on i_clock.
// assumes i_clock runs well above the link clock so every link edge is seen;
// assumes the controller keeps skew between paired pins under one i_clock cycle.
`timescale 1ns/100ps
`include "lpi_regs.svh"
module lpi_top
   import lpi_pkg::*;
(
   input  logic                   i_clock,
   input  logic                   i_rst,
   input  logic                   i_ck_t,
   input  logic                   i_ck_c,
   input  logic                   i_cke,
   input  logic                   i_cs_n,
   input  logic [`LPI_CA_W-1:0]   i_ca,
   input  logic [`LPI_DQ_W-1:0]   i_dq,
   output logic [`LPI_DQ_W-1:0]   o_dq,
   output logic [`LPI_LANES-1:0]  o_dq_oe_n,
   input  logic [`LPI_LANES-1:0]  i_dqs_t,
   input  logic [`LPI_LANES-1:0]  i_dqs_c,
   output logic [`LPI_LANES-1:0]  o_dqs_t,
   output logic [`LPI_LANES-1:0]  o_dqs_c,
   output logic [`LPI_LANES-1:0]  o_dqs_oe_n,
   input  logic [`LPI_LANES-1:0]  i_dm,
   input  logic                   i_odt,
   input  logic                   i_x32,
   input  logic [`LPI_TERM_W-1:0] i_term_sel,
   output logic                   o_term_on,
   output logic [`LPI_TERM_W-1:0] o_term_sel,
   output logic                   o_clk_run,
   output logic                   o_pwr_enter,
   output logic                   o_pwr_exit,
   output logic                   o_cmd_valid,
   output lpi_cmd_t               o_cmd,
   output logic [`LPI_CA_W-1:0]   o_cmd_ca_rise,
   output logic [`LPI_CA_W-1:0]   o_cmd_ca_fall,
   output logic [`LPI_LANES-1:0]  o_wr_store
);
   // -------------------------------------------------------------------------
   // pin synchronisation
   // -------------------------------------------------------------------------
   localparam int SW = 4 + 2 * `LPI_LANES + `LPI_CA_W + `LPI_DQ_W + `LPI_LANES + 2;

   logic [SW-1:0]             sync_q;
   logic                      ck_t_s;
   logic                      ck_c_s;
   logic                      cke_s;
   logic                      cs_n_s;
   logic [`LPI_CA_W-1:0]      ca_s;
   logic [`LPI_DQ_W-1:0]      dq_s;
   logic [`LPI_LANES-1:0]     dqs_t_s;
   logic [`LPI_LANES-1:0]     dqs_c_s;
   logic [`LPI_LANES-1:0]     dm_s;
   logic                      odt_s;
   logic                      x32_s;

   lpi_sync #(
      .W (SW)
   ) u_sync (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_d     ({i_ck_t, i_ck_c, i_cke, i_cs_n, i_ca, i_dq,
                 i_dqs_t, i_dqs_c, i_dm, i_odt, i_x32}),
      .o_q     (sync_q)
   );

   assign {ck_t_s, ck_c_s, cke_s, cs_n_s, ca_s, dq_s,
           dqs_t_s, dqs_c_s, dm_s, odt_s, x32_s} = sync_q;

   // -------------------------------------------------------------------------
   // link clock edges
   // -------------------------------------------------------------------------
   // the level only moves on a complementary sample, so a skewed crossing
   // that shows both wires equal for a sample never makes a false edge
   logic ck_lvl_ff;
   logic ck_cmp;
   logic ck_pos;
   logic ck_neg;

   assign ck_cmp = ck_t_s ^ ck_c_s;
   assign ck_pos = ck_cmp & ck_t_s & ~ck_lvl_ff;
   assign ck_neg = ck_cmp & ~ck_t_s & ck_lvl_ff;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ck_lvl_ff <= 1'b0;
      end else if (ck_cmp) begin
         ck_lvl_ff <= ck_t_s;
      end
   end

   // -------------------------------------------------------------------------
   // command capture
   // -------------------------------------------------------------------------
   logic                  cke_ff;
   logic                  cke_prev_ff;
   logic                  cs_n_ff;
   logic [`LPI_CA_W-1:0]  ca_r_ff;
   logic                  pend_ff;
   logic                  pwr_enter_ff;
   logic                  pwr_exit_ff;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cke_ff       <= `LPI_RST_CKE;
         cke_prev_ff  <= `LPI_RST_CKE;
         cs_n_ff      <= `LPI_RST_CS_N;
         ca_r_ff      <= '0;
         pend_ff      <= 1'b0;
         pwr_enter_ff <= 1'b0;
         pwr_exit_ff  <= 1'b0;
      end else begin
         pwr_enter_ff <= ck_pos & cke_ff & ~cke_s;
         pwr_exit_ff  <= ck_pos & ~cke_ff & cke_s;
         if (ck_pos) begin
            cke_prev_ff <= cke_ff;
            cke_ff      <= cke_s;
            cs_n_ff     <= cs_n_s;
            ca_r_ff     <= ca_s;
            pend_ff     <= 1'b1;
         end else if (ck_neg) begin
            pend_ff <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // command decode, completed on the negative edge of the same cycle
   // -------------------------------------------------------------------------
   logic [`LPI_OP_MSB-`LPI_OP_LSB:0] op;
   lpi_cmd_t                         cmd_dec;
   logic                             cmd_hit;

   assign op      = ca_r_ff[`LPI_OP_MSB:`LPI_OP_LSB];
   assign cmd_dec = (op == LPI_CMD_NOP) ? LPI_CMD_NOP :
                    (op == LPI_CMD_ACT) ? LPI_CMD_ACT :
                    (op == LPI_CMD_WR)  ? LPI_CMD_WR  :
                    (op == LPI_CMD_RD)  ? LPI_CMD_RD  : LPI_CMD_OTHER;
   // clock enable must be high on this and the previous edge, else the
   // cycle belongs to a power-saving transition and is no command
   assign cmd_hit = ck_neg & pend_ff & cke_ff & cke_prev_ff & ~cs_n_ff;

   logic                  cmd_valid_ff;
   lpi_cmd_t              cmd_ff;
   logic [`LPI_CA_W-1:0]  cmd_rise_ff;
   logic [`LPI_CA_W-1:0]  cmd_fall_ff;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cmd_valid_ff <= 1'b0;
         cmd_ff       <= LPI_CMD_NOP;
         cmd_rise_ff  <= '0;
         cmd_fall_ff  <= '0;
      end else begin
         cmd_valid_ff <= cmd_hit;
         if (cmd_hit) begin
            cmd_ff      <= cmd_dec;
            cmd_rise_ff <= ca_r_ff;
            cmd_fall_ff <= ca_s;
         end
      end
   end

   // -------------------------------------------------------------------------
   // burst address, bank from the rising word and column from the falling
   // -------------------------------------------------------------------------
   logic [`LPI_BANK_W-1:0] bank_ff;
   logic [`LPI_COL_W-1:0]  col_ff;
   logic                   is_wr;
   logic                   is_rd;
   logic [`LPI_LANES-1:0]  lane_on;

   assign is_wr = cmd_valid_ff & (cmd_ff == LPI_CMD_WR);
   assign is_rd = cmd_valid_ff & (cmd_ff == LPI_CMD_RD);

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         bank_ff <= '0;
         col_ff  <= '0;
      end else if (is_wr | is_rd) begin
         bank_ff <= cmd_rise_ff[`LPI_BANK_MSB:`LPI_BANK_LSB];
         col_ff  <= cmd_fall_ff[`LPI_COL_MSB:`LPI_COL_LSB];
      end
   end

   // -------------------------------------------------------------------------
   // read burst: one beat per i_clock cycle, strobe toggles with each beat
   // -------------------------------------------------------------------------
   lpi_rd_st_t              rd_st_ff;
   lpi_rd_st_t              nxt_rd_st;
   logic [`LPI_BEAT_W-1:0]  rd_beat_ff;
   logic                    rd_issue;
   logic                    drive_ff;
   logic                    dqs_ff;
   logic [`LPI_ADDR_W-1:0]  rd_addr;
   logic [`LPI_COL_W-1:0]   rd_col;

   assign rd_issue = (rd_st_ff == LPI_ST_READ) & cke_ff;
   assign rd_col   = col_ff + {{(`LPI_COL_W-`LPI_BEAT_W){1'b0}}, rd_beat_ff};
   assign rd_addr  = {bank_ff, rd_col};

   always_comb begin
      nxt_rd_st = rd_st_ff;
      case (rd_st_ff)
         LPI_ST_IDLE: begin
            if (is_rd) begin
               nxt_rd_st = LPI_ST_READ;
            end
         end
         LPI_ST_READ: begin
            if (~cke_ff | (rd_beat_ff == `LPI_LAST_BEAT)) begin
               nxt_rd_st = LPI_ST_IDLE;
            end
         end
         default: begin
            nxt_rd_st = LPI_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rd_st_ff   <= LPI_ST_IDLE;
         rd_beat_ff <= '0;
         drive_ff   <= 1'b0;
         dqs_ff     <= 1'b0;
      end else begin
         rd_st_ff   <= nxt_rd_st;
         rd_beat_ff <= rd_issue ? rd_beat_ff + 1'b1 : '0;
         drive_ff   <= rd_issue;
         dqs_ff     <= rd_issue ? ~dqs_ff : 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // per byte lane: strobe edges, masked write beats, storage and drivers
   // -------------------------------------------------------------------------
   logic [`LPI_BANK_W-1:0] wr_bank_ff;
   logic [`LPI_COL_W-1:0]  wr_col_ff;
   logic [`LPI_LANES-1:0]  store;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wr_bank_ff <= '0;
         wr_col_ff  <= '0;
      end else if (is_wr) begin
         wr_bank_ff <= cmd_rise_ff[`LPI_BANK_MSB:`LPI_BANK_LSB];
         wr_col_ff  <= cmd_fall_ff[`LPI_COL_MSB:`LPI_COL_LSB];
      end
   end

   genvar l;
   generate
      for (l = 0; l < `LPI_LANES; l = l + 1) begin : g_lane
         logic                   dqs_lvl_ff;
         logic                   wr_act_ff;
         logic [`LPI_BEAT_W-1:0] wr_cnt_ff;
         logic                   dqs_cmp;
         logic                   dqs_edge;
         logic [`LPI_COL_W-1:0]  wr_col;
         logic [`LPI_BYTE_W-1:0] rd_byte;

         assign lane_on[l] = (l < `LPI_LANES_X16) | x32_s;
         assign dqs_cmp    = dqs_t_s[l] ^ dqs_c_s[l];
         // both directions count, so each strobe edge is one beat
         assign dqs_edge   = dqs_cmp & (dqs_t_s[l] != dqs_lvl_ff);
         assign store[l]   = wr_act_ff & dqs_edge & ~dm_s[l] & cke_ff;
         assign wr_col     = wr_col_ff + {{(`LPI_COL_W-`LPI_BEAT_W){1'b0}}, wr_cnt_ff};

         always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
               dqs_lvl_ff <= 1'b0;
               wr_act_ff  <= 1'b0;
               wr_cnt_ff  <= '0;
            end else begin
               if (dqs_cmp) begin
                  dqs_lvl_ff <= dqs_t_s[l];
               end
               if (is_wr) begin
                  wr_act_ff <= lane_on[l];
                  wr_cnt_ff <= '0;
               end else if (~cke_ff) begin
                  wr_act_ff <= 1'b0;
               end else if (wr_act_ff & dqs_edge) begin
                  wr_cnt_ff <= wr_cnt_ff + 1'b1;
                  if (wr_cnt_ff == `LPI_LAST_BEAT) begin
                     wr_act_ff <= 1'b0;
                  end
               end
            end
         end

         lpi_mem u_mem (
            .i_clock (i_clock),
            .i_rst   (i_rst),
            .i_we    (store[l]),
            .i_waddr ({wr_bank_ff, wr_col}),
            .i_wdata (dq_s[l*`LPI_BYTE_W +: `LPI_BYTE_W]),
            .i_raddr (rd_addr),
            .o_rdata (rd_byte)
         );

         assign o_dq[l*`LPI_BYTE_W +: `LPI_BYTE_W] = rd_byte;
         // drivers only while reading, clock enabled and the lane exists
         assign o_dq_oe_n[l]  = ~(drive_ff & cke_ff & lane_on[l]);
         assign o_dqs_oe_n[l] = ~(drive_ff & cke_ff & lane_on[l]);
         assign o_dqs_t[l]    = dqs_ff;
         assign o_dqs_c[l]    = ~dqs_ff;
      end
   endgenerate

   // -------------------------------------------------------------------------
   // termination
   // -------------------------------------------------------------------------
   // termination drops one cycle after this end starts driving the bus and returns one cycle after it stops
   logic                   term_on_ff;
   logic [`LPI_TERM_W-1:0] term_sel_ff;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         term_on_ff  <= 1'b0;
         term_sel_ff <= '0;
      end else begin
         term_on_ff  <= odt_s & cke_ff & ~drive_ff;
         term_sel_ff <= i_term_sel;
      end
   end

   // -------------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------------
   assign o_term_on     = term_on_ff;
   assign o_term_sel    = term_sel_ff;
   assign o_clk_run     = cke_ff;
   assign o_pwr_enter   = pwr_enter_ff;
   assign o_pwr_exit    = pwr_exit_ff;
   assign o_cmd_valid   = cmd_valid_ff;
   assign o_cmd         = cmd_ff;
   assign o_cmd_ca_rise = cmd_rise_ff;
   assign o_cmd_ca_fall = cmd_fall_ff;
   assign o_wr_store    = store;
endmodule : lpi_top

// File: tb/lpi_ctrl_model.sv
// lpi_ctrl_model: memory controller facing the lpi pin interface.
// assumes the bench calls one task at a time, after reset release.
`timescale 1ns/100ps
`include "lpi_regs.svh"
module lpi_ctrl_model
   import lpi_pkg::*;
(
   input  logic                  i_clock,
   output logic                  o_ck_t,
   output logic                  o_ck_c,
   output logic                  o_cke,
   output logic                  o_cs_n,
   output logic [`LPI_CA_W-1:0]  o_ca,
   output logic [`LPI_DQ_W-1:0]  o_dq,
   output logic [`LPI_LANES-1:0] o_dqs_t,
   output logic [`LPI_LANES-1:0] o_dqs_c,
   output logic [`LPI_LANES-1:0] o_dm
);
   initial begin
      o_ck_t = 1'b0;
      o_ck_c = 1'b1;
      o_cke = 1'b0;
      o_cs_n = 1'b1;
      o_ca = 10'h000;
      o_dq = 32'h0;
      o_dqs_t = 4'h0;
      o_dqs_c = 4'hF;
      o_dm = 4'h0;
   end
   // link clock stands still between commands; each command is one link cycle
   task automatic send(input logic cke, input logic cs_n, input logic [9:0] rise,
                       input logic [9:0] fall);
      @(posedge i_clock);
      o_ck_t <= 1'b1;
      o_ck_c <= 1'b0;
      o_cke <= cke;
      o_cs_n <= cs_n;
      o_ca <= rise;
      repeat (4) @(posedge i_clock);
      o_ck_t <= 1'b0;
      o_ck_c <= 1'b1;
      o_ca <= fall;
      repeat (4) @(posedge i_clock);
      o_cs_n <= 1'b1;
      o_ca <= ~fall;
   endtask : send
   // strobe edge sits three cycles inside a six-cycle data eye
   task automatic wr_burst(input logic [255:0] d, input logic [31:0] m, input logic x32);
      logic [3:0] ln;
      ln = x32 ? 4'hF : 4'h3;
      for (int k = 0; k < 8; k++) begin
         @(posedge i_clock);
         o_dq <= d[32*k+:32];
         o_dm <= m[4*k+:4];
         repeat (3) @(posedge i_clock);
         o_dqs_t <= k[0] ? 4'h0 : ln;
         o_dqs_c <= k[0] ? 4'hF : ~ln;
         repeat (2) @(posedge i_clock);
      end
      @(posedge i_clock);
      o_dq <= ~d[255:224];
      o_dm <= 4'h0;
   endtask : wr_burst
endmodule : lpi_ctrl_model

// File: tb/lpi_top_assertions.sv
// lpi_top_assertions: port-level checks of the lpi pin interface.
// assumes it is bound into lpi_top and sees only that module's ports.
`timescale 1ns/100ps
`include "lpi_regs.svh"
module lpi_chk
   import lpi_pkg::*;
(
   input logic                  i_clock,
   input logic                  i_rst,
   input logic [`LPI_LANES-1:0] i_dm,
   input logic                  i_x32,
   input logic [`LPI_LANES-1:0] o_dq_oe_n,
   input logic [`LPI_LANES-1:0] o_dqs_t,
   input logic [`LPI_LANES-1:0] o_dqs_oe_n,
   input logic [`LPI_LANES-1:0] o_wr_store,
   input logic                  o_clk_run,
   input logic                  o_pwr_enter,
   input logic                  o_pwr_exit,
   input logic                  o_cmd_valid,
   input lpi_cmd_t              o_cmd,
   input logic [`LPI_CA_W-1:0]  o_cmd_ca_rise
);
   // ------
   // mask resynchronised to line up with its store
   // ------
   logic [`LPI_LANES-1:0] dm_s1_ff;
   logic [`LPI_LANES-1:0] dm_s2_ff;
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         dm_s1_ff <= 4'h0;
         dm_s2_ff <= 4'h0;
      end else begin
         dm_s1_ff <= i_dm;
         dm_s2_ff <= dm_s1_ff;
      end
   end
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);
   property p_enter;
      o_pwr_enter |-> !o_clk_run && $past(o_clk_run);
   endproperty
   a_enter: assert property (p_enter) else $error("entry without clock stop");
   property p_exit;
      $rose(o_clk_run) |-> o_pwr_exit ##1 !o_pwr_exit;
   endproperty
   a_exit: assert property (p_exit) else $error("clock start without exit pulse");
   property p_cmd_cke;
      o_cmd_valid |-> o_clk_run;
   endproperty
   a_cmd_cke: assert property (p_cmd_cke) else $error("command while clocks off");
   property p_cmd_dec;
      o_cmd_valid |-> o_cmd == ((o_cmd_ca_rise[2:0] > 3'h3) ? LPI_CMD_OTHER
                                : lpi_cmd_t'(o_cmd_ca_rise[2:0]));
   endproperty
   a_cmd_dec: assert property (p_cmd_dec) else $error("command decode wrong");
   property p_cmd_hold;
      !o_cmd_valid |-> $stable(o_cmd) && $stable(o_cmd_ca_rise);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("command moved unasked");
   property p_rd_len;
      $fell(o_dq_oe_n[0]) |-> (!o_dq_oe_n[0] || !o_clk_run) [*8] ##1 o_dq_oe_n[0];
   endproperty
   a_rd_len: assert property (p_rd_len) else $error("read burst length wrong");
   property p_rd_strobe;
      !o_dq_oe_n[0] |-> o_dqs_t[0] != $past(o_dqs_t[0]);
   endproperty
   a_rd_strobe: assert property (p_rd_strobe) else $error("strobe not toggling");
   property p_dqs_oe;
      o_dqs_oe_n == o_dq_oe_n;
   endproperty
   a_dqs_oe: assert property (p_dqs_oe) else $error("strobe drive apart from data");
   property p_mask;
      (o_wr_store & dm_s2_ff) == 4'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("masked byte stored");
   property p_x16;
      !i_x32 && !$past(i_x32, 3) |-> o_wr_store[3:2] == 2'h0 && o_dq_oe_n[3:2] == 2'h3;
   endproperty
   a_x16: assert property (p_x16) else $error("upper lanes active in x16");
   c_read: cover property ($fell(o_dq_oe_n[0]));
   c_store: cover property (|o_wr_store);
   c_enter: cover property (o_pwr_enter);
endmodule : lpi_chk
bind lpi_top lpi_chk i_chk (
   .i_clock(i_clock), .i_rst(i_rst), .i_dm(i_dm), .i_x32(i_x32), .o_dq_oe_n(o_dq_oe_n),
   .o_dqs_t(o_dqs_t), .o_dqs_oe_n(o_dqs_oe_n), .o_wr_store(o_wr_store),
   .o_clk_run(o_clk_run), .o_pwr_enter(o_pwr_enter), .o_pwr_exit(o_pwr_exit),
   .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_cmd_ca_rise(o_cmd_ca_rise)
);

// File: tb/lpi_top_tb_top.sv
// lpi_top_tb_top: self-checking bench for the lpi pin interface.
// assumes lpi_ctrl_model plays the controller; shared pins are resolved here.
`timescale 1ns/100ps
`include "lpi_regs.svh"
module lpi_top_tb_top
   import lpi_pkg::*;
;
   logic        clk, rst, x32, odt, ck_t, ck_c, cke, cs_n;
   logic        term_on, clk_run, pwr_enter, pwr_exit, cmd_valid;
   logic [1:0]  term_sel, term_sel_o;
   logic [9:0]  ca, ca_rise, ca_fall;
   logic [31:0] c_dq, d_dq, dq_w;
   logic [3:0]  c_dqs_t, c_dqs_c, d_dqs_t, d_dqs_c, dqs_t_w, dqs_c_w;
   logic [3:0]  dm, dq_oe_n, dqs_oe_n, store;
   lpi_cmd_t    cmd;
   int          errors, samples_checked, n_enter, n_exit;
   int          st_cnt[4];
   logic [22:0] cmd_q[$];
   logic [39:0] rd_q[$];
   for (genvar l = 0; l < 4; l++) begin : g_lane
      assign dq_w[8*l+:8] = dq_oe_n[l] ? c_dq[8*l+:8] : d_dq[8*l+:8];
      assign dqs_t_w[l] = dqs_oe_n[l] ? c_dqs_t[l] : d_dqs_t[l];
      assign dqs_c_w[l] = dqs_oe_n[l] ? c_dqs_c[l] : d_dqs_c[l];
   end
   lpi_ctrl_model i_ctrl (.i_clock(clk), .o_ck_t(ck_t), .o_ck_c(ck_c), .o_cke(cke),
      .o_cs_n(cs_n), .o_ca(ca), .o_dq(c_dq), .o_dqs_t(c_dqs_t), .o_dqs_c(c_dqs_c), .o_dm(dm));
   lpi_top i_dut (.i_clock(clk), .i_rst(rst), .i_ck_t(ck_t), .i_ck_c(ck_c), .i_cke(cke),
      .i_cs_n(cs_n), .i_ca(ca), .i_dq(dq_w), .o_dq(d_dq), .o_dq_oe_n(dq_oe_n),
      .i_dqs_t(dqs_t_w), .i_dqs_c(dqs_c_w), .o_dqs_t(d_dqs_t), .o_dqs_c(d_dqs_c),
      .o_dqs_oe_n(dqs_oe_n), .i_dm(dm), .i_odt(odt), .i_x32(x32), .i_term_sel(term_sel),
      .o_term_on(term_on), .o_term_sel(term_sel_o), .o_clk_run(clk_run),
      .o_pwr_enter(pwr_enter), .o_pwr_exit(pwr_exit), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
      .o_cmd_ca_rise(ca_rise), .o_cmd_ca_fall(ca_fall), .o_wr_store(store));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) cmd_q.push_back({cmd, ca_rise, ca_fall});
      if (dq_oe_n !== 4'hF) rd_q.push_back({dq_oe_n, d_dqs_t, d_dq});
      if (pwr_enter === 1'b1) n_enter++;
      if (pwr_exit === 1'b1) n_exit++;
      for (int l = 0; l < 4; l++) if (store[l] === 1'b1) st_cnt[l]++;
   end
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk
   task automatic complete_run();
      if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task automatic do_cmd(input logic ck_en, input logic sel_n, input logic [9:0] rise,
                         input logic [9:0] fall, input int n_exp);
      logic [2:0] op;
      i_ctrl.send(ck_en, sel_n, rise, fall);
      repeat (3) @(posedge clk);
      @(negedge clk);
      op = (rise[2:0] > 3'h3) ? 3'h4 : rise[2:0];
      chk("cmd count", n_exp, cmd_q.size());
      if (cmd_q.size() == 1) chk("cmd word", {op, rise, fall}, cmd_q[0]);
      cmd_q.delete();
   endtask : do_cmd
   task automatic t_power();
      @(negedge clk);
      chk("oe_n at reset", 4'hF, dq_oe_n);
      chk("dqs_c at reset", 4'hF, d_dqs_c);
      chk("cmd at reset", LPI_CMD_NOP, cmd);
      @(posedge clk);
      odt <= 1'b1;
      do_cmd(1'b1, 1'b1, 10'h000, 10'h000, 0);
      chk("exit", 1, n_exit);
      chk("clk_run", 1'b1, clk_run);
      chk("term_on", 1'b1, term_on);
      chk("term_sel", 2'h2, term_sel_o);
      do_cmd(1'b0, 1'b1, 10'h000, 10'h000, 0);
      chk("enter", 1, n_enter);
      chk("clk_run off", 1'b0, clk_run);
      chk("term off", 1'b0, term_on);
      do_cmd(1'b0, 1'b0, 10'h003, 10'h000, 0);
      do_cmd(1'b1, 1'b0, 10'h003, 10'h000, 0);
      chk("exit again", 2, n_exit);
      @(posedge clk);
      odt <= 1'b0;
   endtask : t_power
   task automatic t_cmds();
      logic [2:0] ops[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h7};
      for (int k = 0; k < 5; k++) do_cmd(1'b1, 1'b0, {3'(k), 4'hA, ops[k]}, 10'h2A0, 1);
      do_cmd(1'b1, 1'b1, 10'h001, 10'h000, 0);
   endtask : t_cmds
   task automatic t_wr_rd(input logic x);
      logic [255:0] a;
      logic [31:0]  m, lm, dmask;
      logic [3:0]   act;
      int           i;
      act = x ? 4'hF : 4'h3;
      dmask = {{8{act[3]}}, {8{act[2]}}, {8{act[1]}}, {8{act[0]}}};
      for (int k = 0; k < 8; k++) begin
         a[32*k+:32] = 32'h31211101 + {4{8'(k)}};
         m[4*k+:4] = 4'h1 << (k % 4);
      end
      for (i = 0; i < 4; i++) st_cnt[i] = 0;
      do_cmd(1'b1, 1'b0, 10'h2C2, 10'h01E, 1);
      i_ctrl.wr_burst(a, 32'h0, x);
      do_cmd(1'b1, 1'b0, 10'h2C2, 10'h01E, 1);
      i_ctrl.wr_burst(~a, m, x);
      repeat (4) @(posedge clk);
      for (i = 0; i < 4; i++) chk("stores", act[i] ? 14 : 0, st_cnt[i]);
      rd_q.delete();
      do_cmd(1'b1, 1'b0, 10'h2C3, 10'h01E, 1);
      for (i = 0; i < 40 && rd_q.size() < 8; i++) @(posedge clk);
      if (rd_q.size() < 8) begin
         errors++;
         complete_run();
      end
      repeat (4) @(posedge clk);
      chk("beats", 8, rd_q.size());
      for (int k = 0; k < 8; k++) begin
         lm = 32'hFF << (8 * (k % 4));
         chk("read beat", {~act, (k % 2) ? 4'h0 : act, ((a[32*k+:32] & lm) | (~a[32*k+:32] & ~lm))
             & dmask}, rd_q[k] & {4'hF, act, dmask});
      end
   endtask : t_wr_rd
   initial begin
      rst = 1'b1;
      x32 = 1'b1;
      odt = 1'b0;
      term_sel = 2'h2;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_power();
      t_cmds();
      t_wr_rd(1'b1);
      @(posedge clk);
      rst <= 1'b1;
      x32 <= 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      i_ctrl.send(1'b1, 1'b1, 10'h000, 10'h000);
      t_wr_rd(1'b0);
      complete_run();
   end
endmodule : lpi_top_tb_top
